// >>> src/density_loss_detector.sv
// Purpose: Pulse-density loss detector on the received bit stream.
// Assumes: One received bit per clock, already synchronised.
// Notes: Forced clear and idle while not enabled.
`timescale 1ns/1ns
module density_loss_detector #(
	parameter int ZERO_RUN = los_pkg::ZERO_RUN_BITS,
	parameter int WINDOW = los_pkg::WINDOW_BITS,
	parameter int MIN_ONES = los_pkg::WINDOW_ONES,
	parameter int WINDOWS = los_pkg::CLEAR_WINDOWS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Stream and control
	input wire logic bit_in,
	input wire logic enable,
	// Result
	output logic loss
);
	import los_pkg::*;

	typedef struct packed {
		logic [7:0] zero_cnt;
		logic [4:0] win_cnt;
		logic [3:0] ones_cnt;
		logic [1:0] good_cnt;
		logic loss;
	} dens_s;

	dens_s q;
	dens_s d;

	always_comb begin
		logic [4:0] ones_tot;
		ones_tot = 5'h00;
		d = q;
		if (!enable) begin
			d = '0;
		end else if (!q.loss) begin
			d.win_cnt = 5'h00;
			d.ones_cnt = 4'h0;
			d.good_cnt = 2'h0;
			if (bit_in) begin
				d.zero_cnt = 8'h00;
			end else if (q.zero_cnt == 8'(ZERO_RUN - 1)) begin
				d.loss = 1'b1;
				d.zero_cnt = 8'h00;
			end else begin
				d.zero_cnt = q.zero_cnt + 8'h01;
			end
		end else begin
			d.zero_cnt = 8'h00;
			ones_tot = {1'b0, q.ones_cnt} + {4'h0, bit_in};
			if (q.win_cnt == 5'(WINDOW - 1)) begin
				d.win_cnt = 5'h00;
				d.ones_cnt = 4'h0;
				if (ones_tot >= 5'(MIN_ONES)) begin
					if (q.good_cnt == 2'(WINDOWS - 1)) begin
						d.loss = 1'b0;
						d.good_cnt = 2'h0;
					end else begin
						d.good_cnt = q.good_cnt + 2'h1;
					end
				end else begin
					d.good_cnt = 2'h0;
				end
			end else begin
				d.win_cnt = q.win_cnt + 5'h01;
				if (ones_tot >= 5'(MIN_ONES)) begin
					d.ones_cnt = 4'(MIN_ONES);
				end else begin
					d.ones_cnt = ones_tot[3:0];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign loss = q.loss;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	zero_run_declare_a: assert property (
		enable && !q.loss && !bit_in && q.zero_cnt == 8'h9f |=> q.loss)
		else $error("density loss not declared after zero run");
	run_restart_a: assert property (
		enable && !q.loss && bit_in |=> q.zero_cnt == 8'h00 && !q.loss)
		else $error("zero run count not restarted by a one");
	density_clear_a: assert property (
		$fell(q.loss) && $past(enable) |->
		$past(q.good_cnt) == 2'h3 && $past(q.win_cnt) == 5'h1f)
		else $error("density loss cleared without four good windows");
	density_off_a: assert property (
		!enable |=> !q.loss)
		else $error("density loss declared while detector off");
	density_declare_c: cover property ($rose(q.loss));
	density_clear_c: cover property ($fell(q.loss) && enable);

endmodule

// >>> src/line_loss_of_signal_monitor.sv
// Purpose: Receive signal-loss monitor and codec enable control.
// Assumes: MCLK is the line-rate clock; amplitude declare and clear
// indications arrive synchronous to MCLK from the analog front end.
// Notes: Register port is the decoded side of the host serial port.
// How it works
// - Hardware mode: codec bypass output follows the external bypass pin.
// - Host mode: control bit D3 set disables encoder and decoder.
// - Missing signal drives loss output high and sets status bit.
// - Restored signal drives loss output low and clears status bit.
// - E3 mode: loss follows amplitude declare and clear levels only.
// - Loss declared and cleared between 10 and 255 unit intervals.
// - DS3/STS-1 mode: loss is OR of amplitude and density loss.
// - Amplitude declare below low level, clear above higher level.
// - Status holds lock-lost, combined, amplitude, density, driver flag.
// - Host control bit D2 set stops any amplitude loss declaration.
// - Host control bit D1 set stops any density loss declaration.
// - Both detectors off suppresses the combined loss indication.
// - Density loss after a run of 160 consecutive zero bits.
// - Density clears after four back-to-back 32-bit windows of at least ten ones.
// - No line or frequency error asserts lock lost, reference clock.
`timescale 1ns/1ns
module line_loss_of_signal_monitor (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// Register port
	input wire logic [los_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [los_pkg::DATA_W-1:0] REG_WDATA,
	output logic [los_pkg::DATA_W-1:0] REG_RDATA,
	// Mode and strap pins
	input wire logic HOST_MODE,
	input wire logic E3_MODE,
	input wire logic CODEC_BYPASS_PIN,
	input wire logic EQUALIZER_OFF_PIN,
	// Line side
	input wire logic RX_DATA,
	input wire logic AMP_DECLARE,
	input wire logic AMP_CLEAR,
	input wire logic FREQ_ERROR,
	input wire logic DRIVER_MONITOR_FLAG,
	// Results
	output logic COMBINED_SIGNAL_LOSS,
	output logic RECEIVE_LOCK_LOST,
	output logic CLOCK_FROM_REFERENCE,
	output logic CODEC_BYPASS,
	output logic EQUALIZER_OFF
);
	import los_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic [DATA_W-1:0] ctl;
		logic amp_loss;
		logic [7:0] amp_cnt;
		logic comb;
		logic lol;
		logic bypass;
		logic eq_off;
		logic [DATA_W-1:0] rdata;
	} mon_s;

	localparam mon_s MON_RESET = '{
		sync1: '0,
		sync2: '0,
		ctl: CONTROL_RESET,
		amp_loss: 1'b0,
		amp_cnt: 8'h00,
		comb: 1'b0,
		lol: 1'b0,
		bypass: 1'b0,
		eq_off: 1'b0,
		rdata: '0
	};

	mon_s q;
	mon_s d;
	logic dens_loss;
	logic host;
	logic amp_off;
	logic dens_off;
	logic [SYNC_W-1:0] pins;

	function automatic logic addr_is(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] target);
		addr_is = (a == target);
	endfunction

	assign pins = {FREQ_ERROR, DRIVER_MONITOR_FLAG, HOST_MODE, E3_MODE,
		EQUALIZER_OFF_PIN, CODEC_BYPASS_PIN, RX_DATA};
	assign host = q.sync2[SY_HOST];
	assign amp_off = host && q.ctl[CTL_AMPLITUDE_OFF];
	assign dens_off = host && q.ctl[CTL_DENSITY_OFF];

	density_loss_detector #(
		.ZERO_RUN(ZERO_RUN_BITS),
		.WINDOW(WINDOW_BITS),
		.MIN_ONES(WINDOW_ONES),
		.WINDOWS(CLEAR_WINDOWS)
	) u_density (
		.clk(MCLK),
		.rst_b(RST_B),
		.bit_in(q.sync2[SY_RX_DATA]),
		.enable(!dens_off),
		.loss(dens_loss)
	);

	always_comb begin
		logic amp_cond;
		amp_cond = 1'b0;
		d = q;
		// Two-flop synchroniser; only the second stage is read
		d.sync1 = pins;
		d.sync2 = q.sync1;

		// Host writes; reserved D4 never stored
		if (REG_WR && addr_is(REG_ADDR, RECEIVE_CONTROL_ADDR)) begin
			d.ctl = REG_WDATA & CONTROL_WR_MASK;
		end

		// Amplitude filter on front-end declare/clear flags
		amp_cond = q.amp_loss ? AMP_CLEAR : AMP_DECLARE;
		if (amp_off) begin
			d.amp_loss = 1'b0;
			d.amp_cnt = 8'h00;
		end else if (amp_cond) begin
			if (q.amp_cnt == 8'(AMP_FILTER_CYC - 1)) begin
				d.amp_loss = !q.amp_loss;
				d.amp_cnt = 8'h00;
			end else begin
				d.amp_cnt = q.amp_cnt + 8'h01;
			end
		end else begin
			d.amp_cnt = 8'h00;
		end

		// Combined loss; E3 uses amplitude only
		if (amp_off && dens_off) begin
			d.comb = 1'b0;
		end else if (q.sync2[SY_E3]) begin
			d.comb = q.amp_loss;
		end else begin
			d.comb = q.amp_loss || dens_loss;
		end

		// No line or off-frequency: lock lost, run from reference
		d.lol = q.amp_loss || q.sync2[SY_FREQ_ERR];

		// Codec and equalizer from host bits or from pins
		d.bypass = host ? q.ctl[CTL_CODEC_BYPASS]
			: q.sync2[SY_CODEC];
		d.eq_off = host ? q.ctl[CTL_EQUALIZER_OFF] : q.sync2[SY_EQ_OFF];

		// Read data; unmapped addresses read zero
		if (addr_is(REG_ADDR, RECEIVE_STATUS_ADDR)) begin
			d.rdata = '0;
			d.rdata[ST_LOCK_LOST] = q.lol;
			d.rdata[ST_COMBINED_LOSS] = q.comb;
			d.rdata[ST_AMPLITUDE_LOSS] = q.amp_loss;
			d.rdata[ST_DENSITY_LOSS] = dens_loss;
			d.rdata[ST_DRIVER_MONITOR] = q.sync2[SY_DRV_MON];
		end else if (addr_is(REG_ADDR, RECEIVE_CONTROL_ADDR)) begin
			d.rdata = q.ctl;
		end else begin
			d.rdata = '0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			q <= MON_RESET;
		end else begin
			q <= d;
		end
	end

	assign REG_RDATA = q.rdata;
	assign COMBINED_SIGNAL_LOSS = q.comb;
	assign RECEIVE_LOCK_LOST = q.lol;
	assign CLOCK_FROM_REFERENCE = q.lol;
	assign CODEC_BYPASS = q.bypass;
	assign EQUALIZER_OFF = q.eq_off;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	codec_pin_follow_a: assert property (
		!host && q.sync2[SY_CODEC] |=> CODEC_BYPASS)
		else $error("codec bypass does not follow the pin");
	codec_host_bit_a: assert property (
		host && $past(host) && q.ctl[CTL_CODEC_BYPASS] == 1'b0
		|=> !CODEC_BYPASS)
		else $error("codec not enabled by host bit");
	loss_status_match_a: assert property (
		addr_is(REG_ADDR, RECEIVE_STATUS_ADDR)
		|=> REG_RDATA[ST_COMBINED_LOSS] == $past(COMBINED_SIGNAL_LOSS))
		else $error("loss status bit differs from loss output");
	loss_release_a: assert property (
		!q.amp_loss && !dens_loss && !(amp_off && dens_off)
		|=> !COMBINED_SIGNAL_LOSS)
		else $error("loss output held after signal restored");
	e3_amp_only_a: assert property (
		q.sync2[SY_E3] && !(amp_off && dens_off)
		|=> COMBINED_SIGNAL_LOSS == $past(q.amp_loss))
		else $error("e3 loss not taken from amplitude");
	amp_declare_time_a: assert property (
		$rose(q.amp_loss) |-> $past(AMP_DECLARE, 1) && $past(AMP_DECLARE, 32)
		&& !$past(q.amp_loss, 32))
		else $error("amplitude loss declared before the filter time");
	ds3_or_a: assert property (
		!q.sync2[SY_E3] && !(amp_off && dens_off)
		|=> COMBINED_SIGNAL_LOSS == $past(q.amp_loss || dens_loss))
		else $error("ds3 loss is not the or of both detectors");
	status_fields_a: assert property (
		addr_is(REG_ADDR, RECEIVE_STATUS_ADDR) |=>
		REG_RDATA[ST_AMPLITUDE_LOSS] == $past(q.amp_loss)
		&& REG_RDATA[ST_DENSITY_LOSS] == $past(dens_loss)
		&& REG_RDATA[ST_LOCK_LOST] == $past(q.lol))
		else $error("status register fields misplaced");
	amp_off_a: assert property (
		amp_off |=> !q.amp_loss)
		else $error("amplitude loss declared while detector off");
	both_off_a: assert property (
		amp_off && dens_off |=> !COMBINED_SIGNAL_LOSS)
		else $error("loss declared with both detectors off");
	lock_lost_a: assert property (
		q.sync2[SY_FREQ_ERR] |=> RECEIVE_LOCK_LOST && CLOCK_FROM_REFERENCE)
		else $error("lock lost not raised on frequency error");
	amp_clear_hold_a: assert property (
		q.amp_loss && !AMP_CLEAR && !amp_off |=> q.amp_loss)
		else $error("amplitude loss cleared without clear flag");

	// Register port
	ctl_write_a: assert property (
		REG_WR && addr_is(REG_ADDR, RECEIVE_CONTROL_ADDR)
		|=> q.ctl == $past(REG_WDATA & CONTROL_WR_MASK))
		else $error("control register write not stored");
	reserved_zero_a: assert property (
		q.ctl[DATA_W-1] == 1'b0)
		else $error("reserved control bit stored");
	ctl_hold_a: assert property (
		!(REG_WR && addr_is(REG_ADDR, RECEIVE_CONTROL_ADDR))
		|=> q.ctl == $past(q.ctl))
		else $error("control register changed without a write");
	ctl_read_a: assert property (
		addr_is(REG_ADDR, RECEIVE_CONTROL_ADDR) |=> REG_RDATA == $past(q.ctl))
		else $error("control register read back wrong");
	unmapped_read_a: assert property (
		!addr_is(REG_ADDR, RECEIVE_STATUS_ADDR)
		&& !addr_is(REG_ADDR, RECEIVE_CONTROL_ADDR)
		|=> REG_RDATA == '0)
		else $error("unmapped address read not zero");
	driver_flag_a: assert property (
		addr_is(REG_ADDR, RECEIVE_STATUS_ADDR)
		|=> REG_RDATA[ST_DRIVER_MONITOR]
		== $past(q.sync2[SY_DRV_MON]))
		else $error("driver monitor flag misplaced in status");

	// Codec control
	codec_pin_low_a: assert property (
		!host && !q.sync2[SY_CODEC] |=> !CODEC_BYPASS)
		else $error("codec disabled while bypass pin low");
	codec_host_set_a: assert property (
		host && q.ctl[CTL_CODEC_BYPASS] |=> CODEC_BYPASS)
		else $error("codec not disabled by host bit");

	// Loss timing and gating
	amp_clear_time_a: assert property (
		$fell(q.amp_loss) && !$past(amp_off) |-> $past(AMP_CLEAR, 1)
		&& $past(AMP_CLEAR, 32) && $past(q.amp_loss, 32))
		else $error("amplitude loss cleared before the filter time");
	amp_filter_max_a: assert property (
		q.amp_cnt < 8'(AMP_FILTER_CYC))
		else $error("amplitude filter count out of range");
	amp_cnt_restart_a: assert property (
		!amp_off && !(q.amp_loss ? AMP_CLEAR : AMP_DECLARE)
		|=> q.amp_cnt == 8'h00 && q.amp_loss == $past(q.amp_loss))
		else $error("amplitude filter not restarted");
	amp_declare_hold_a: assert property (
		!q.amp_loss && !AMP_DECLARE |=> !q.amp_loss)
		else $error("amplitude loss declared without declare flag");
	loss_raise_a: assert property (
		!(amp_off && dens_off)
		&& (q.amp_loss || (dens_loss && !q.sync2[SY_E3]))
		|=> COMBINED_SIGNAL_LOSS)
		else $error("loss output not raised on signal loss");
	e3_no_density_a: assert property (
		q.sync2[SY_E3] && !q.amp_loss |=> !COMBINED_SIGNAL_LOSS)
		else $error("e3 loss raised without amplitude loss");
	density_gate_a: assert property (
		dens_off |=> !dens_loss)
		else $error("density loss seen while detector off");
	lock_amp_a: assert property (
		q.amp_loss |=> RECEIVE_LOCK_LOST)
		else $error("lock lost not raised with no line input");
	lock_release_a: assert property (
		!q.amp_loss && !q.sync2[SY_FREQ_ERR] |=> !RECEIVE_LOCK_LOST)
		else $error("lock lost held after line restored");
	ref_clock_a: assert property (
		CLOCK_FROM_REFERENCE == RECEIVE_LOCK_LOST)
		else $error("clock source differs from lock state");

	loss_declare_c: cover property ($rose(COMBINED_SIGNAL_LOSS));
	loss_clear_c: cover property ($fell(COMBINED_SIGNAL_LOSS));
	e3_loss_c: cover property (q.sync2[SY_E3] && $rose(q.amp_loss));
	host_bypass_c: cover property (host && $rose(CODEC_BYPASS));
	dens_loss_c: cover property (!q.sync2[SY_E3] && $rose(dens_loss));

endmodule

// >>> src/los_pkg.sv
// Purpose: Shared constants for the line signal-loss monitor.
// Assumes: MCLK is the line-rate clock, one bit period per cycle.
// Notes: Register map, field positions and timing counts.
package los_pkg;

	// Register port
	localparam int ADDR_W = 5;
	localparam int DATA_W = 5;
	localparam logic [4:0] RECEIVE_STATUS_ADDR = 5'h00;
	localparam logic [4:0] RECEIVE_CONTROL_ADDR = 5'h02;

	// receive_control fields
	localparam int CTL_EQUALIZER_OFF = 0;
	localparam int CTL_DENSITY_OFF = 1;
	localparam int CTL_AMPLITUDE_OFF = 2;
	localparam int CTL_CODEC_BYPASS = 3;
	localparam logic [4:0] CONTROL_WR_MASK = 5'h0f;
	localparam logic [4:0] CONTROL_RESET = 5'h00;

	// receive_status fields
	localparam int ST_DRIVER_MONITOR = 0;
	localparam int ST_DENSITY_LOSS = 1;
	localparam int ST_AMPLITUDE_LOSS = 2;
	localparam int ST_COMBINED_LOSS = 3;
	localparam int ST_LOCK_LOST = 4;

	// Synchroniser lanes for pin inputs
	localparam int SYNC_W = 7;
	localparam int SY_RX_DATA = 0;
	localparam int SY_CODEC = 1;
	localparam int SY_EQ_OFF = 2;
	localparam int SY_E3 = 3;
	localparam int SY_HOST = 4;
	localparam int SY_DRV_MON = 5;
	localparam int SY_FREQ_ERR = 6;

	// Timing in unit intervals, and cycles derived from it
	localparam int UI_PER_CYCLE = 1;
	localparam int LOS_MIN_UI = 10;
	localparam int LOS_MAX_UI = 255;
	localparam int AMP_FILTER_UI = 32;
	localparam int AMP_FILTER_CYC = AMP_FILTER_UI / UI_PER_CYCLE;

	// Pulse-density detector
	localparam int ZERO_RUN_BITS = 160;
	localparam int WINDOW_BITS = 32;
	localparam int WINDOW_ONES = 10;
	localparam int CLEAR_WINDOWS = 4;

endpackage

// >>> testbench/line_front_end.sv
// Purpose: Line front end model: bit stream and amplitude flags.
// Assumes: Updates 2 ns after each MCLK rising edge.
// Notes: Mode 0 random, 1 zeros, 2 ones, 3 nine ones per 32 bits.
`timescale 1ns/1ns
module line_front_end (
	input wire logic clk,
	input wire logic [1:0] data_mode,
	input wire logic amp_lost,
	output logic rx_data,
	output logic amp_declare,
	output logic amp_clear
);
	logic [4:0] bit_cnt = 5'h00;
	initial begin
		rx_data = 1'b0;
		amp_declare = 1'b0;
		amp_clear = 1'b1;
	end
	always @(posedge clk) begin
		#2;
		bit_cnt <= bit_cnt + 5'h01;
		amp_declare <= amp_lost;
		amp_clear <= ~amp_lost;
		case (data_mode)
			2'h0: rx_data <= 1'($urandom);
			2'h1: rx_data <= 1'b0;
			2'h2: rx_data <= 1'b1;
			default: rx_data <= (bit_cnt < 5'h09);
		endcase
	end
endmodule

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the line signal-loss monitor.
// Assumes: Inputs change 1 ns after the MCLK rising edge.
// Notes: Random control words and line bits from a fixed seed.
`timescale 1ns/1ns
module tb_top;
	import los_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [ADDR_W-1:0] addr = 5'h00;
	logic wr = 1'b0;
	logic [DATA_W-1:0] wdata = 5'h00;
	logic [DATA_W-1:0] rdata;
	logic host = 1'b1, e3 = 1'b0, byp_pin = 1'b0, eq_pin = 1'b0;
	logic freq_err = 1'b0, drv = 1'b0, amp_lost = 1'b0;
	logic [1:0] data_mode = 2'h0;
	logic rx, amp_dec, amp_clr, comb, lock, ref_clk, byp, eq;
	int failures = 0;
	int checked = 0;
	always #20 mclk = ~mclk;
	line_front_end fe (.clk(mclk), .data_mode(data_mode),
		.amp_lost(amp_lost), .rx_data(rx), .amp_declare(amp_dec),
		.amp_clear(amp_clr));
	line_loss_of_signal_monitor dut (.MCLK(mclk), .RST_B(rst_b),
		.REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .HOST_MODE(host), .E3_MODE(e3),
		.CODEC_BYPASS_PIN(byp_pin), .EQUALIZER_OFF_PIN(eq_pin),
		.RX_DATA(rx), .AMP_DECLARE(amp_dec), .AMP_CLEAR(amp_clr),
		.FREQ_ERROR(freq_err), .DRIVER_MONITOR_FLAG(drv),
		.COMBINED_SIGNAL_LOSS(comb), .RECEIVE_LOCK_LOST(lock),
		.CLOCK_FROM_REFERENCE(ref_clk), .CODEC_BYPASS(byp),
		.EQUALIZER_OFF(eq));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic check(input string what, input logic [4:0] seen,
		input logic [4:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_write(input logic [4:0] a, input logic [4:0] data);
		addr = a;
		wr = 1'b1;
		wdata = data;
		tick(1);
		wr = 1'b0;
	endtask
	task automatic reg_read(input logic [4:0] a, output logic [4:0] d);
		addr = a;
		tick(1);
		d = rdata;
	endtask
	function automatic logic [4:0] status(input logic lk, cb, am, dn);
		return {lk, cb, am, dn, drv};
	endfunction
	task automatic check_status(input logic [4:0] exp);
		logic [4:0] d;
		reg_read(RECEIVE_STATUS_ADDR, d);
		check("status", d, exp);
	endtask
	task automatic conclude;
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		tick(20000);
		failures++;
		conclude();
	end
	initial begin
		logic [4:0] d;
		logic [4:0] w;
		void'($urandom(32'hf29a));
		tick(16);
		rst_b = 1'b1;
		tick(1);
		check("outputs", {comb, lock, ref_clk, byp, eq}, 5'h00);
		reg_read(RECEIVE_CONTROL_ADDR, d);
		check("control reset", d, CONTROL_RESET);
		for (int i = 0; i < 5; i++) begin
			w = (i == 0) ? 5'h1f : 5'($urandom);
			reg_write(RECEIVE_CONTROL_ADDR, w);
			reg_read(RECEIVE_CONTROL_ADDR, d);
			check("control", d, w & CONTROL_WR_MASK);
			tick(1);
			check("codec", {3'h0, byp, eq}, {3'h0, w[3], w[0]});
		end
		reg_write(RECEIVE_STATUS_ADDR, 5'h00);
		reg_read(RECEIVE_CONTROL_ADDR, d);
		check("control kept", d, w & CONTROL_WR_MASK);
		reg_read(5'h05, d);
		check("unmapped", d, 5'h00);
		reg_write(RECEIVE_CONTROL_ADDR, 5'h00);
		host = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{byp_pin, eq_pin} = 2'(i);
			tick(4);
			check("pins", {3'h0, byp, eq}, 5'(i));
		end
		{byp_pin, eq_pin} = 2'h0;
		host = 1'b1;
		for (int m = 0; m < 2; m++) begin
			e3 = 1'(m);
			drv = !drv;
			tick(4);
			amp_lost = 1'b1;
			tick(9);
			check("loss early", {4'h0, comb}, 5'h00);
			tick(31);
			check("loss", {4'h0, comb}, 5'h01);
			check_status(status(1'b1, 1'b1, 1'b1, 1'b0));
			amp_lost = 1'b0;
			tick(9);
			check("clear early", {4'h0, comb}, 5'h01);
			tick(31);
			check("clear", {4'h0, comb}, 5'h00);
		end
		e3 = 1'b0;
		tick(4);
		data_mode = 2'h1;
		tick(120);
		check("zeros short", {4'h0, comb}, 5'h00);
		tick(80);
		check("zeros", {4'h0, comb}, 5'h01);
		check_status(status(1'b0, 1'b1, 1'b0, 1'b1));
		data_mode = 2'h3;
		tick(300);
		check("sparse", {4'h0, comb}, 5'h01);
		data_mode = 2'h2;
		tick(200);
		check("dense", {4'h0, comb}, 5'h00);
		e3 = 1'b1;
		data_mode = 2'h1;
		tick(250);
		check("e3 zeros", {4'h0, comb}, 5'h00);
		check_status(status(1'b0, 1'b0, 1'b0, 1'b1));
		data_mode = 2'h2;
		e3 = 1'b0;
		tick(200);
		reg_write(RECEIVE_CONTROL_ADDR, 5'h06);
		amp_lost = 1'b1;
		data_mode = 2'h1;
		tick(300);
		check("both off", {4'h0, comb}, 5'h00);
		check_status(status(1'b0, 1'b0, 1'b0, 1'b0));
		reg_write(RECEIVE_CONTROL_ADDR, 5'h04);
		tick(250);
		check("amp off", {4'h0, comb}, 5'h01);
		check_status(status(1'b0, 1'b1, 1'b0, 1'b1));
		reg_write(RECEIVE_CONTROL_ADDR, 5'h00);
		amp_lost = 1'b0;
		data_mode = 2'h2;
		tick(250);
		freq_err = 1'b1;
		tick(4);
		check("lock", {3'h0, lock, ref_clk}, 5'h03);
		check_status(status(1'b1, 1'b0, 1'b0, 1'b0));
		freq_err = 1'b0;
		tick(4);
		check("relock", {3'h0, lock, ref_clk}, 5'h00);
		reg_write(RECEIVE_CONTROL_ADDR, 5'h0f);
		tick(2);
		check("codec set", {3'h0, byp, eq}, 5'h03);
		rst_b = 1'b0;
		tick(3);
		rst_b = 1'b1;
		tick(1);
		check("outputs rst", {comb, lock, ref_clk, byp, eq}, 5'h00);
		reg_read(RECEIVE_CONTROL_ADDR, d);
		check("control rst", d, CONTROL_RESET);
		conclude();
	end
endmodule
